/* File: core/htm_link_if.sv */
`timescale 1ns/1ps
interface htm_link_if;
  logic dev_scl_out;
  logic dev_scl_oe;
  logic dev_sda_out;
  logic dev_sda_oe;
  logic host_scl_out;
  logic host_scl_oe;
  logic host_sda_out;
  logic host_sda_oe;
  logic result_ready_out;
  logic scl;
  logic sda;

  // open-drain wired-and with pull-up
  assign scl = ~((dev_scl_oe & ~dev_scl_out) | (host_scl_oe & ~host_scl_out));
  assign sda = ~((dev_sda_oe & ~dev_sda_out) | (host_sda_oe & ~host_sda_out));

  modport dev (input scl, input sda, output dev_scl_out, output dev_scl_oe,
               output dev_sda_out, output dev_sda_oe, output result_ready_out);
  modport host (input scl, input sda, input result_ready_out, output host_scl_out,
                output host_scl_oe, output host_sda_out, output host_sda_oe);
endinterface

/* File: core/htm_pkg.sv */
package htm_pkg;
  localparam int unsigned CLK_HZ        = 10_000_000;
  localparam int unsigned CLK_PERIOD_NS = 1_000_000_000 / CLK_HZ;
  localparam logic [6:0]  TGT_ADDR      = 7'h28;
  localparam logic [7:0]  CTRL_OFS      = 8'h0c;
  localparam logic [7:0]  STAT_OFS      = 8'h0d;
  localparam logic [7:0]  CTRL_RST      = 8'h00;
  localparam int          STATE_LSB     = 0;
  localparam int          HEAT_BIT      = 3;
  localparam int          STBY_LSB      = 4;
  localparam int          STAT_ERR_BIT  = 0;
  localparam int          STAT_BUSY_BIT = 1;
  localparam int          STAT_STBY_BIT = 2;
  localparam logic [2:0]  SET_SLEEP     = 3'h0;
  localparam logic [2:0]  SET_MEAS      = 3'h1;
  localparam logic [2:0]  SET_RESET     = 3'h4;
  localparam logic [2:0]  STBY_400      = 3'h3;
  localparam logic [2:0]  STBY_1000     = 3'h4;
  localparam logic [2:0]  STBY_ONESHOT  = 3'h7;
  localparam int unsigned MEAS_TIME_US  = 1000;
  localparam int unsigned MEAS_CYC      = MEAS_TIME_US * (CLK_HZ / 1_000_000);
  localparam int unsigned BOOT_TIME_US  = 500;
  localparam int unsigned BOOT_CYC      = BOOT_TIME_US * (CLK_HZ / 1_000_000);
  localparam int unsigned STBY_100_MS   = 100;
  localparam int unsigned STBY_100_CYC  = STBY_100_MS * (CLK_HZ / 1000);
  localparam int unsigned STBY_400_MS   = 400;
  localparam int unsigned STBY_400_CYC  = STBY_400_MS * (CLK_HZ / 1000);
  localparam int unsigned STBY_1000_MS  = 1000;
  localparam int unsigned STBY_1000_CYC = STBY_1000_MS * (CLK_HZ / 1000);
  localparam int unsigned POWERUP_MS    = 15;
  localparam int unsigned POWERUP_CYC   = POWERUP_MS * (CLK_HZ / 1000);
  localparam int unsigned SCL_PERIOD_NS = 800;
  localparam int unsigned SCL_QTR_CYC   = SCL_PERIOD_NS / (4 * CLK_PERIOD_NS);

  typedef enum logic [1:0] {
    KIND_WR_CTRL = 2'h0,
    KIND_RD_RES  = 2'h1,
    KIND_RD_STAT = 2'h2
  } htm_kind_t;

  typedef enum logic [2:0] {
    OP_START = 3'h0,
    OP_WR    = 3'h1,
    OP_RDA   = 3'h2,
    OP_RDN   = 3'h3,
    OP_STOP  = 3'h4
  } htm_op_t;
endpackage

/* File: core/htm_sensor_dev.sv */
`timescale 1ns/1ps
module htm_sensor_dev
  import htm_pkg::*;
#(
  parameter int unsigned MEAS_CYCLES      = MEAS_CYC,
  parameter int unsigned BOOT_CYCLES      = BOOT_CYC,
  parameter int unsigned STBY_100_CYCLES  = STBY_100_CYC,
  parameter int unsigned STBY_400_CYCLES  = STBY_400_CYC,
  parameter int unsigned STBY_1000_CYCLES = STBY_1000_CYC
) (
  input  wire logic        sys_clk,
  input  wire logic        reset,
  input  wire logic        clk_en,
  htm_link_if.dev          lnk,
  input  wire logic [15:0] sample_humidity,
  input  wire logic [15:0] sample_temp,
  input  wire logic        boot_ok,
  output logic             heater_on,
  output logic             meas_active
);
  typedef enum logic [1:0] {
    M_BOOT  = 2'h0,
    M_SLEEP = 2'h1,
    M_MEAS  = 2'h2,
    M_STBY  = 2'h3
  } htm_mstate_t;

  typedef enum logic [2:0] {
    I_IDLE   = 3'h0,
    I_RX     = 3'h1,
    I_ACK_TX = 3'h2,
    I_TX     = 3'h3,
    I_ACK_RX = 3'h4
  } htm_istate_t;

  logic [1:0]  scl_sync_reg;
  logic [1:0]  sda_sync_reg;
  logic        scl_prev_reg;
  logic        sda_prev_reg;
  logic        scl_s;
  logic        sda_s;
  logic        start_det;
  logic        stop_det;
  logic        scl_rise;
  logic        scl_fall;
  htm_istate_t istate_reg;
  logic [3:0]  bit_cnt_reg;
  logic [7:0]  shift_reg;
  logic [7:0]  tx_reg;
  logic        is_addr_reg;
  logic        rw_reg;
  logic [7:0]  ptr_reg;
  logic        ptr_valid_reg;
  logic [1:0]  rd_idx_reg;
  logic        nack_reg;
  logic        sda_oe_reg;
  logic        ctrl_wr_reg;
  logic [7:0]  ctrl_wdata_reg;
  logic        res_read_reg;
  logic [7:0]  ctrl_reg;
  htm_mstate_t mstate_reg;
  logic [31:0] timer_reg;
  logic        err_reg;
  logic [31:0] result_reg;
  logic        ready_reg;
  logic        refuse;
  logic        meas_done;
  logic [7:0]  status_byte;
  logic [7:0]  tx_byte;

  function automatic logic [31:0] stby_cycles(input logic [2:0] code);
    case (code)
      STBY_400:  stby_cycles = 32'(STBY_400_CYCLES - 1);
      STBY_1000: stby_cycles = 32'(STBY_1000_CYCLES - 1);
      default:   stby_cycles = 32'(STBY_100_CYCLES - 1);
    endcase
  endfunction

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      scl_sync_reg <= 2'h3;
      sda_sync_reg <= 2'h3;
      scl_prev_reg <= 1'b1;
      sda_prev_reg <= 1'b1;
    end else if (clk_en) begin
      scl_sync_reg <= {scl_sync_reg[0], lnk.scl};
      sda_sync_reg <= {sda_sync_reg[0], lnk.sda};
      scl_prev_reg <= scl_sync_reg[1];
      sda_prev_reg <= sda_sync_reg[1];
    end
  end

  assign scl_s     = scl_sync_reg[1];
  assign sda_s     = sda_sync_reg[1];
  assign start_det = scl_s & scl_prev_reg & sda_prev_reg & ~sda_s;
  assign stop_det  = scl_s & scl_prev_reg & ~sda_prev_reg & sda_s;
  assign scl_rise  = scl_s & ~scl_prev_reg;
  assign scl_fall  = ~scl_s & scl_prev_reg;
  assign refuse    = (mstate_reg == M_BOOT) | err_reg;

  always_comb begin
    status_byte = 8'h00;
    status_byte[STAT_ERR_BIT]  = err_reg;
    status_byte[STAT_BUSY_BIT] = (mstate_reg == M_MEAS);
    status_byte[STAT_STBY_BIT] = (mstate_reg == M_STBY);
  end

  // pointer set in this transfer selects a register, else results
  always_comb begin
    if (ptr_valid_reg) begin
      if (ptr_reg == STAT_OFS) begin
        tx_byte = status_byte;
      end else if (ptr_reg == CTRL_OFS) begin
        tx_byte = ctrl_reg;
      end else begin
        tx_byte = 8'h00;
      end
    end else begin
      case (rd_idx_reg)
        2'h0:    tx_byte = result_reg[31:24];
        2'h1:    tx_byte = result_reg[23:16];
        2'h2:    tx_byte = result_reg[15:8];
        default: tx_byte = result_reg[7:0];
      endcase
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      istate_reg     <= I_IDLE;
      bit_cnt_reg    <= 4'h0;
      shift_reg      <= 8'h00;
      tx_reg         <= 8'h00;
      is_addr_reg    <= 1'b0;
      rw_reg         <= 1'b0;
      ptr_reg        <= 8'h00;
      ptr_valid_reg  <= 1'b0;
      rd_idx_reg     <= 2'h0;
      nack_reg       <= 1'b0;
      sda_oe_reg     <= 1'b0;
      ctrl_wr_reg    <= 1'b0;
      ctrl_wdata_reg <= 8'h00;
      res_read_reg   <= 1'b0;
    end else if (clk_en) begin
      ctrl_wr_reg  <= 1'b0;
      res_read_reg <= 1'b0;
      if (stop_det) begin
        istate_reg    <= I_IDLE;
        ptr_valid_reg <= 1'b0;
        sda_oe_reg    <= 1'b0;
      end else if (start_det) begin
        istate_reg  <= I_RX;
        bit_cnt_reg <= 4'h0;
        is_addr_reg <= 1'b1;
        sda_oe_reg  <= 1'b0;
      end else if (scl_rise) begin
        if (istate_reg == I_RX) begin
          shift_reg   <= {shift_reg[6:0], sda_s};
          bit_cnt_reg <= bit_cnt_reg + 4'h1;
        end else if (istate_reg == I_ACK_RX) begin
          nack_reg <= sda_s;
        end
      end else if (scl_fall) begin
        case (istate_reg)
          I_RX: begin
            if (bit_cnt_reg == 4'h8) begin
              is_addr_reg <= 1'b0;
              if (is_addr_reg) begin
                if (shift_reg[7:1] == TGT_ADDR && !refuse) begin
                  rw_reg     <= shift_reg[0];
                  sda_oe_reg <= 1'b1;
                  istate_reg <= I_ACK_TX;
                  rd_idx_reg <= 2'h0;
                  res_read_reg <= shift_reg[0] & ~ptr_valid_reg;
                end else begin
                  istate_reg <= I_IDLE;
                end
              end else begin
                sda_oe_reg <= 1'b1;
                istate_reg <= I_ACK_TX;
                if (!ptr_valid_reg) begin
                  ptr_reg       <= shift_reg;
                  ptr_valid_reg <= 1'b1;
                end else begin
                  ptr_reg <= ptr_reg + 8'h01;
                  if (ptr_reg == CTRL_OFS) begin
                    ctrl_wr_reg    <= 1'b1;
                    ctrl_wdata_reg <= shift_reg;
                  end
                end
              end
            end
          end
          I_ACK_TX, I_ACK_RX: begin
            if ((istate_reg == I_ACK_TX && !rw_reg) || (istate_reg == I_ACK_RX && nack_reg)) begin
              sda_oe_reg  <= 1'b0;
              bit_cnt_reg <= 4'h0;
              istate_reg  <= (istate_reg == I_ACK_TX) ? I_RX : I_IDLE;
            end else begin
              sda_oe_reg  <= ~tx_byte[7];
              tx_reg      <= {tx_byte[6:0], 1'b0};
              bit_cnt_reg <= 4'h1;
              istate_reg  <= I_TX;
              if (ptr_valid_reg) begin
                ptr_reg <= ptr_reg + 8'h01;
              end else begin
                rd_idx_reg <= rd_idx_reg + 2'h1;
              end
            end
          end
          I_TX: begin
            if (bit_cnt_reg == 4'h8) begin
              sda_oe_reg <= 1'b0;
              istate_reg <= I_ACK_RX;
            end else begin
              sda_oe_reg  <= ~tx_reg[7];
              tx_reg      <= {tx_reg[6:0], 1'b0};
              bit_cnt_reg <= bit_cnt_reg + 4'h1;
            end
          end
          default: ;
        endcase
      end
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      ctrl_reg <= CTRL_RST;
    end else if (clk_en && ctrl_wr_reg) begin
      ctrl_reg <= (ctrl_wdata_reg[STATE_LSB+:3] == SET_RESET) ? CTRL_RST : ctrl_wdata_reg;
    end
  end

  assign meas_done = (mstate_reg == M_MEAS) && (timer_reg == 32'h0) &&
                     !(ctrl_wr_reg && ctrl_wdata_reg[STATE_LSB+:3] == SET_RESET);

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      mstate_reg <= M_BOOT;
      timer_reg  <= 32'(BOOT_CYCLES - 1);
      err_reg    <= 1'b0;
    end else if (clk_en) begin
      if (ctrl_wr_reg && ctrl_wdata_reg[STATE_LSB+:3] == SET_RESET) begin
        mstate_reg <= M_BOOT;
        timer_reg  <= 32'(BOOT_CYCLES - 1);
      end else begin
        case (mstate_reg)
          M_BOOT: begin
            if (timer_reg == 32'h0) begin
              err_reg    <= ~boot_ok;
              mstate_reg <= M_SLEEP;
            end else begin
              timer_reg <= timer_reg - 32'h1;
            end
          end
          M_SLEEP: begin
            if (ctrl_wr_reg && ctrl_wdata_reg[STATE_LSB+:3] == SET_MEAS) begin
              mstate_reg <= M_MEAS;
              timer_reg  <= 32'(MEAS_CYCLES - 1);
            end
          end
          M_MEAS: begin
            if (timer_reg == 32'h0) begin
              if (ctrl_reg[STATE_LSB+:3] == SET_MEAS &&
                  ctrl_reg[STBY_LSB+:3] != STBY_ONESHOT) begin
                mstate_reg <= M_STBY;
                timer_reg  <= stby_cycles(ctrl_reg[STBY_LSB+:3]);
              end else begin
                mstate_reg <= M_SLEEP;
              end
            end else begin
              timer_reg <= timer_reg - 32'h1;
            end
          end
          M_STBY: begin
            if (ctrl_wr_reg && ctrl_wdata_reg[STATE_LSB+:3] == SET_SLEEP) begin
              mstate_reg <= M_SLEEP;
            end else if ((ctrl_wr_reg && ctrl_wdata_reg[STATE_LSB+:3] == SET_MEAS) ||
                         timer_reg == 32'h0) begin
              mstate_reg <= M_MEAS;
              timer_reg  <= 32'(MEAS_CYCLES - 1);
            end else begin
              timer_reg <= timer_reg - 32'h1;
            end
          end
          default: mstate_reg <= M_SLEEP;
        endcase
      end
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      result_reg <= 32'h0;
    end else if (clk_en && meas_done) begin
      result_reg <= {sample_humidity, sample_temp};
    end
  end

  // a new completion wins over a result read that clears it
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      ready_reg <= 1'b0;
    end else if (clk_en) begin
      if (meas_done) begin
        ready_reg <= 1'b1;
      end else if (res_read_reg) begin
        ready_reg <= 1'b0;
      end
    end
  end

  assign lnk.result_ready_out = ready_reg;
  assign lnk.dev_sda_oe       = sda_oe_reg;
  assign lnk.dev_sda_out      = 1'b0;
  assign lnk.dev_scl_oe       = 1'b0;
  assign lnk.dev_scl_out      = 1'b0;
  assign heater_on            = ctrl_reg[HEAT_BIT];
  assign meas_active          = (mstate_reg == M_MEAS);
endmodule

/* File: core/htm_sensor_host.sv */
`timescale 1ns/1ps
module htm_sensor_host
  import htm_pkg::*;
#(
  parameter int unsigned POWERUP_CYCLES = POWERUP_CYC
) (
  input  wire logic        sys_clk,
  input  wire logic        reset,
  input  wire logic        clk_en,
  htm_link_if.host         lnk,
  input  wire logic        cmd_valid,
  output logic             cmd_ready,
  input  wire logic [1:0]  cmd_kind,
  input  wire logic [7:0]  cmd_data,
  output logic             rsp_valid,
  output logic             rsp_nack,
  output logic [31:0]      rsp_data,
  output logic             ready_seen
);
  typedef enum logic [1:0] {
    H_WAIT = 2'h0,
    H_IDLE = 2'h1,
    H_RUN  = 2'h2
  } htm_hstate_t;

  htm_hstate_t hstate_reg;
  logic [31:0] wait_reg;
  htm_kind_t   kind_reg;
  logic [7:0]  data_reg;
  logic [2:0]  step_reg;
  logic [1:0]  q_reg;
  logic [7:0]  div_reg;
  logic [3:0]  bit_cnt_reg;
  logic        nack_reg;
  logic        abort_reg;
  logic [31:0] shift_reg;
  logic        valid_reg;
  logic [1:0]  sda_sync_reg;
  logic [1:0]  rdy_sync_reg;
  logic        scl_oe_reg;
  logic        sda_oe_reg;
  logic [10:0] plan;
  htm_op_t     cur_op;
  logic [7:0]  cur_byte;
  logic        tick;
  logic        scl_low;
  logic        sda_low;

  // transfer plan: one slot per step, address always 28h
  function automatic logic [10:0] host_plan(input htm_kind_t k, input logic [2:0] s,
                                            input logic [7:0] d);
    host_plan = {OP_STOP, 8'h00};
    case (k)
      KIND_WR_CTRL: begin
        case (s)
          3'h0:    host_plan = {OP_START, 8'h00};
          3'h1:    host_plan = {OP_WR, TGT_ADDR, 1'b0};
          3'h2:    host_plan = {OP_WR, CTRL_OFS};
          3'h3:    host_plan = {OP_WR, d};
          default: host_plan = {OP_STOP, 8'h00};
        endcase
      end
      KIND_RD_RES: begin
        case (s)
          3'h0:    host_plan = {OP_START, 8'h00};
          3'h1:    host_plan = {OP_WR, TGT_ADDR, 1'b1};
          3'h2, 3'h3, 3'h4: host_plan = {OP_RDA, 8'h00};
          3'h5:    host_plan = {OP_RDN, 8'h00};
          default: host_plan = {OP_STOP, 8'h00};
        endcase
      end
      KIND_RD_STAT: begin
        case (s)
          3'h0, 3'h3: host_plan = {OP_START, 8'h00};
          3'h1:    host_plan = {OP_WR, TGT_ADDR, 1'b0};
          3'h2:    host_plan = {OP_WR, STAT_OFS};
          3'h4:    host_plan = {OP_WR, TGT_ADDR, 1'b1};
          3'h5:    host_plan = {OP_RDN, 8'h00};
          default: host_plan = {OP_STOP, 8'h00};
        endcase
      end
      default: host_plan = {OP_STOP, 8'h00};
    endcase
  endfunction

  assign plan     = host_plan(kind_reg, step_reg, data_reg);
  assign cur_op   = abort_reg ? OP_STOP : htm_op_t'(plan[10:8]);
  assign cur_byte = plan[7:0];
  assign tick     = (div_reg == 8'h00);

  always_comb begin
    scl_low = 1'b0;
    sda_low = 1'b0;
    if (hstate_reg == H_RUN) begin
      case (cur_op)
        OP_START: begin
          scl_low = (q_reg[0] == q_reg[1]);
          sda_low = q_reg[1];
        end
        OP_STOP: begin
          scl_low = (q_reg == 2'h0);
          sda_low = ~q_reg[1];
        end
        OP_WR: begin
          scl_low = (q_reg[0] == q_reg[1]);
          sda_low = (bit_cnt_reg != 4'h8) && !cur_byte[3'h7 - bit_cnt_reg[2:0]];
        end
        OP_RDA, OP_RDN: begin
          scl_low = (q_reg[0] == q_reg[1]);
          sda_low = (bit_cnt_reg == 4'h8) && (cur_op == OP_RDA);
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      sda_sync_reg <= 2'h3;
      rdy_sync_reg <= 2'h0;
      scl_oe_reg   <= 1'b0;
      sda_oe_reg   <= 1'b0;
    end else if (clk_en) begin
      sda_sync_reg <= {sda_sync_reg[0], lnk.sda};
      rdy_sync_reg <= {rdy_sync_reg[0], lnk.result_ready_out};
      scl_oe_reg   <= scl_low;
      sda_oe_reg   <= sda_low;
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      hstate_reg  <= H_WAIT;
      wait_reg    <= 32'(POWERUP_CYCLES - 1);
      kind_reg    <= KIND_WR_CTRL;
      data_reg    <= 8'h00;
      step_reg    <= 3'h0;
      q_reg       <= 2'h0;
      div_reg     <= 8'h00;
      bit_cnt_reg <= 4'h0;
      nack_reg    <= 1'b0;
      abort_reg   <= 1'b0;
      shift_reg   <= 32'h0;
      valid_reg   <= 1'b0;
    end else if (clk_en) begin
      case (hstate_reg)
        H_WAIT: begin
          if (wait_reg == 32'h0) begin
            hstate_reg <= H_IDLE;
          end else begin
            wait_reg <= wait_reg - 32'h1;
          end
        end
        H_IDLE: begin
          valid_reg <= 1'b0;
          if (cmd_valid) begin
            kind_reg    <= htm_kind_t'(cmd_kind);
            data_reg    <= cmd_data;
            step_reg    <= 3'h0;
            q_reg       <= 2'h0;
            div_reg     <= 8'(SCL_QTR_CYC - 1);
            bit_cnt_reg <= 4'h0;
            nack_reg    <= 1'b0;
            abort_reg   <= 1'b0;
            shift_reg   <= 32'h0;
            hstate_reg  <= H_RUN;
          end
        end
        H_RUN: begin
          if (!tick) begin
            div_reg <= div_reg - 8'h01;
          end else begin
            div_reg <= 8'(SCL_QTR_CYC - 1);
            q_reg   <= q_reg + 2'h1;
            if (q_reg == 2'h2) begin
              if (cur_op == OP_WR && bit_cnt_reg == 4'h8) begin
                nack_reg <= sda_sync_reg[1];
              end else if ((cur_op == OP_RDA || cur_op == OP_RDN) && bit_cnt_reg != 4'h8) begin
                shift_reg <= {shift_reg[30:0], sda_sync_reg[1]};
              end
            end
            if (q_reg == 2'h3) begin
              if (cur_op == OP_STOP) begin
                valid_reg  <= 1'b1;
                hstate_reg <= H_IDLE;
              end else if (cur_op == OP_START || bit_cnt_reg == 4'h8) begin
                bit_cnt_reg <= 4'h0;
                step_reg    <= step_reg + 3'h1;
                abort_reg   <= nack_reg;
              end else begin
                bit_cnt_reg <= bit_cnt_reg + 4'h1;
              end
            end
          end
        end
        default: hstate_reg <= H_IDLE;
      endcase
    end
  end

  assign cmd_ready        = (hstate_reg == H_IDLE);
  assign rsp_valid        = valid_reg;
  assign rsp_nack         = nack_reg;
  assign rsp_data         = shift_reg;
  assign ready_seen       = rdy_sync_reg[1];
  assign lnk.host_scl_oe  = scl_oe_reg;
  assign lnk.host_sda_oe  = sda_oe_reg;
  assign lnk.host_scl_out = 1'b0;
  assign lnk.host_sda_out = 1'b0;
endmodule

/* File: tb/htm_link_sva.sv */
`timescale 1ns/1ps
module htm_link_sva #(
  parameter int unsigned BOOT_CYCLES    = 10,
  parameter int unsigned POWERUP_CYCLES = 6000
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic scl,
  input wire logic sda,
  input wire logic dev_scl_out,
  input wire logic dev_scl_oe,
  input wire logic dev_sda_out,
  input wire logic dev_sda_oe,
  input wire logic host_scl_out,
  input wire logic host_scl_oe,
  input wire logic host_sda_out,
  input wire logic host_sda_oe,
  input wire logic result_ready_out
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);
  logic [15:0] up_cnt_reg;
  logic        scl_q_reg;
  logic        sda_q_reg;
  logic        busy_reg;
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) up_cnt_reg <= 16'h0;
    else if (up_cnt_reg != 16'hffff) up_cnt_reg <= up_cnt_reg + 16'h1;
  end
  // start sets, stop clears
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      scl_q_reg <= 1'b1;
      sda_q_reg <= 1'b1;
      busy_reg  <= 1'b0;
    end else begin
      scl_q_reg <= scl;
      sda_q_reg <= sda;
      if (scl && scl_q_reg && sda_q_reg && !sda) busy_reg <= 1'b1;
      else if (scl && scl_q_reg && !sda_q_reg && sda) busy_reg <= 1'b0;
    end
  end
  scl_undriven_a: assert property (!dev_scl_oe && !dev_scl_out)
    else $error("device drove the clock line");
  pull_low_a: assert property (!dev_sda_out && !host_sda_out && !host_scl_out)
    else $error("open drain output not low");
  drive_low_a: assert property ($rose(dev_sda_oe) |-> !scl)
    else $error("device took data line while clock high");
  hold_high_a: assert property (scl && $past(scl) |-> $stable(dev_sda_oe))
    else $error("device data changed while clock high");
  clk_high_a: assert property ($rose(scl) |-> scl [*4])
    else $error("clock high phase too short");
  powerup_quiet_a: assert property (up_cnt_reg < POWERUP_CYCLES - 2 |->
    !host_scl_oe && !host_sda_oe) else $error("host used link too early");
  boot_quiet_a: assert property (up_cnt_reg < BOOT_CYCLES |->
    !dev_sda_oe && !result_ready_out) else $error("device active during boot");
  ready_hold_a: assert property (result_ready_out && !busy_reg |=> result_ready_out)
    else $error("ready dropped outside a transfer");
  ready_clear_a: assert property ($fell(result_ready_out) |-> busy_reg)
    else $error("ready cleared with bus idle");
  cover property ($rose(result_ready_out));
  cover property ($rose(dev_sda_oe));
  cover property ($fell(busy_reg));
endmodule

/* File: tb/humidity_temp_measure_ctrl_test.sv */
`timescale 1ns/1ps
module humidity_temp_measure_ctrl_test import htm_pkg::*;;
  logic        sys_clk = 1'b0, reset = 1'b1, cmd_valid = 1'b0, cmd_valid2 = 1'b0;
  logic        clk_en = 1'b1, boot_good = 1'b1, heater_on, meas_active;
  logic [1:0]  cmd_kind = 2'h0;
  logic [7:0]  cmd_data = 8'h00;
  logic [15:0] hum = 16'h0, tmp = 16'h0;
  logic        cmd_ready, rsp_valid, rsp_nack, ready_seen, cmd_ready2, rsp_valid2, rsp_nack2;
  logic [31:0] rsp_data;
  logic [33:0] exp_q[$], mon_e;
  int          mismatches = 0, samples_checked = 0;
  always #50 sys_clk = ~sys_clk;
  htm_link_if lnk();
  htm_link_if lnk2();
  htm_sensor_dev #(.MEAS_CYCLES(20), .BOOT_CYCLES(10), .STBY_100_CYCLES(50),
    .STBY_400_CYCLES(80), .STBY_1000_CYCLES(120)) htm_sensor_dev_inst (.sys_clk, .reset,
    .clk_en, .lnk(lnk.dev), .sample_humidity(hum), .sample_temp(tmp), .boot_ok(boot_good),
    .heater_on, .meas_active);
  htm_sensor_host #(.POWERUP_CYCLES(6000)) htm_sensor_host_inst (.sys_clk, .reset,
    .clk_en, .lnk(lnk.host), .cmd_valid, .cmd_ready, .cmd_kind, .cmd_data,
    .rsp_valid, .rsp_nack, .rsp_data, .ready_seen);
  // second pair: device whose boot failed
  htm_sensor_dev #(.BOOT_CYCLES(10)) htm_sensor_dev_inst_b (.sys_clk, .reset,
    .clk_en, .lnk(lnk2.dev), .sample_humidity(hum), .sample_temp(tmp), .boot_ok(1'b0),
    .heater_on(), .meas_active());
  htm_sensor_host #(.POWERUP_CYCLES(6000)) htm_sensor_host_inst_b (.sys_clk, .reset,
    .clk_en, .lnk(lnk2.host), .cmd_valid(cmd_valid2), .cmd_ready(cmd_ready2),
    .cmd_kind, .cmd_data, .rsp_valid(rsp_valid2), .rsp_nack(rsp_nack2), .rsp_data(),
    .ready_seen());
  htm_link_sva #(.BOOT_CYCLES(10), .POWERUP_CYCLES(6000)) htm_link_sva_inst (.sys_clk,
    .reset, .scl(lnk.scl), .sda(lnk.sda), .dev_scl_out(lnk.dev_scl_out),
    .dev_scl_oe(lnk.dev_scl_oe), .dev_sda_out(lnk.dev_sda_out), .dev_sda_oe(lnk.dev_sda_oe),
    .host_scl_out(lnk.host_scl_out), .host_scl_oe(lnk.host_scl_oe),
    .host_sda_out(lnk.host_sda_out), .host_sda_oe(lnk.host_sda_oe),
    .result_ready_out(lnk.result_ready_out));
  task check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  task conclude;
    $display("mismatches=%0d samples_checked=%0d", mismatches, samples_checked);
    if (mismatches == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // e = {check data, expected nack, expected data}
  task send(input logic [1:0] k, input logic [7:0] d, input logic [33:0] e);
    repeat (9000) if (cmd_ready !== 1'b1) @(negedge sys_clk);
    exp_q.push_back(e);
    @(posedge sys_clk);
    cmd_kind  <= k;
    cmd_data  <= d;
    cmd_valid <= 1'b1;
    @(posedge sys_clk);
    cmd_valid <= 1'b0;
    @(negedge sys_clk);
    repeat (2000) if (rsp_valid !== 1'b1) @(negedge sys_clk);
  endtask
  task wait_ready;
    repeat (3000) if (ready_seen !== 1'b1) @(negedge sys_clk);
    check({31'h0, ready_seen}, 32'h1);
  endtask
  // new samples, then a short freeze: scl, sda and meas_active may not move while enable is low
  task new_samples;
    logic [2:0] snap;
    @(posedge sys_clk);
    hum    <= 16'($urandom);
    tmp    <= 16'($urandom);
    clk_en <= 1'b0;
    @(negedge sys_clk);
    snap = {lnk.scl, lnk.sda, meas_active};
    repeat (2 + $urandom % 4) @(negedge sys_clk);
    check({29'h0, lnk.scl, lnk.sda, meas_active}, {29'h0, snap});
    @(posedge sys_clk);
    clk_en <= 1'b1;
    @(negedge sys_clk);
  endtask
  always @(negedge sys_clk) if (rsp_valid === 1'b1) begin
    mon_e = exp_q.pop_front();
    check({31'h0, rsp_nack}, {31'h0, mon_e[32]});
    if (mon_e[33]) check(rsp_data, mon_e[31:0]);
  end
  initial begin
    repeat (80000) @(posedge sys_clk);
    mismatches++;
    conclude();
  end
  initial begin
    void'($urandom(32'hfd6c760a));
    repeat (20) @(posedge sys_clk);
    reset <= 1'b0;
    send(KIND_RD_STAT, 8'h00, {2'b10, 32'h0});
    @(posedge sys_clk);
    cmd_valid2 <= 1'b1;
    @(posedge sys_clk);
    cmd_valid2 <= 1'b0;
    repeat (2000) if (rsp_valid2 !== 1'b1) @(negedge sys_clk);
    check({30'h0, rsp_valid2, rsp_nack2}, 32'h3);
    for (int i = 0; i < 2; i++) begin
      new_samples();
      send(KIND_WR_CTRL, {1'b0, STBY_ONESHOT, i[0], SET_MEAS}, 34'h0);
      check({31'h0, heater_on}, {31'h0, i[0]});
      wait_ready();
      send(KIND_RD_RES, 8'h00, {2'b10, hum, tmp});
      send(KIND_RD_STAT, 8'h00, {2'b10, 32'h0});
      check({31'h0, ready_seen}, 32'h0);
      check({31'h0, meas_active}, 32'h0);
    end
    for (int s = 0; s < 7; s++) begin
      send(KIND_WR_CTRL, {1'b0, 3'(s), 1'b0, SET_MEAS}, 34'h0);
      new_samples();
      wait_ready();
      send(KIND_RD_RES, 8'h00, 34'h0);
      repeat (300) if (meas_active !== 1'b1) @(negedge sys_clk);
      check({31'h0, meas_active}, 32'h1);
      wait_ready();
      send(KIND_RD_RES, 8'h00, {2'b10, hum, tmp});
    end
    send(KIND_WR_CTRL, {1'b0, 3'h0, 1'b0, SET_SLEEP}, 34'h0);
    repeat (200) @(posedge sys_clk);
    send(KIND_RD_RES, 8'h00, 34'h0);
    repeat (400) @(posedge sys_clk);
    check({31'h0, ready_seen}, 32'h0);
    // reboot with a failing boot load: the device must then refuse the link
    @(posedge sys_clk);
    boot_good <= 1'b0;
    send(KIND_WR_CTRL, {5'h00, SET_RESET}, 34'h0);
    check({31'h0, heater_on}, 32'h0);
    send(KIND_RD_STAT, 8'h00, {2'b01, 32'h0});
    conclude();
  end
endmodule
